/* File: verilog/per_pkg.sv */
// Constants for the peripheral event router: register map, field
// positions, reset values and enabling codes.
// Assumes a 32-bit AHB-Lite bus with word-aligned register offsets.
package per_pkg;

    // Generator and user counts
    localparam int NUM_CMP   = 8;
    localparam int NUM_PA    = 24;
    localparam int NUM_PB    = 16;
    localparam int NUM_AST   = 3;
    localparam int NUM_TC_CH = 3;
    localparam int NUM_WAKE  = 3;

    // Register byte offsets
    localparam logic [7:0] REG_GEN_EN  = 8'h00;
    localparam logic [7:0] REG_USER_EN = 8'h04;
    localparam logic [7:0] REG_MODE    = 8'h08;
    localparam logic [7:0] REG_COUNT   = 8'h0c;
    localparam logic [7:0] REG_WAKE    = 8'h10;

    // Generator enable fields
    localparam int GEN_CMP  = 0;
    localparam int GEN_PIN  = 1;
    localparam int GEN_AST  = 2;
    localparam int GEN_PWM0 = 5;
    localparam int GEN_W    = 6;

    // User enable fields
    localparam int USR_PWM   = 0;
    localparam int USR_TC    = 1;
    localparam int USR_CMP   = 2;
    localparam int USR_TOUCH = 3;
    localparam int USR_W     = 4;

    // Mode register fields
    localparam int CFG_LSB = 0;
    localparam int TRG_LSB = 4;

    // Wake request bit order
    localparam int WK_CMP   = 0;
    localparam int WK_ADC   = 1;
    localparam int WK_TOUCH = 2;

    // Values after reset and enabling codes
    localparam logic [GEN_W-1:0] GEN_EN_RST  = 6'h00;
    localparam logic [USR_W-1:0] USER_EN_RST = 4'h0;
    localparam logic [1:0]       CFG_RST     = 2'h0;
    localparam logic [2:0]       TRG_RST     = 3'h0;
    localparam logic [1:0]       CMP_CFG_EVT = 2'h3;
    localparam logic [2:0]       ADC_TRG_EVT = 3'h7;
    localparam int               COUNT_W     = 16;

endpackage

/* File: verilog/per_edge_pulse.sv */
// Rising-edge detector turning generator levels into one-cycle pulses.
// Assumes inputs are synchronous to hclk.
`timescale 1ns/1ns

module per_edge_pulse #(
    parameter int W = 8
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] pulse
);

    logic [W-1:0] prev_reg;

    // Previous sample of each level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level;
        end
    end

    // One pulse per rising edge
    assign pulse = level & ~prev_reg;

endmodule

/* File: verilog/per_event_router.sv */
// Peripheral event router: fixed network from event generators to
// event users, with enables and modes reached over AHB-Lite.
// Assumes one hclk domain, synchronous generator levels, and a bus
// master that issues single word transfers with no pipelining.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module per_event_router #(
    parameter int PWM_CH = 32
) (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic                          hready,
    input  wire logic [31:0]                   hwdata,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic      [31:0]                   hrdata,
    input  wire logic [per_pkg::NUM_CMP-1:0]   cmp_above,
    input  wire logic [per_pkg::NUM_CMP-1:0]   cmp_below,
    input  wire logic [per_pkg::NUM_PA-1:0]    pin_change_a,
    input  wire logic [per_pkg::NUM_PB-1:0]    pin_change_b,
    input  wire logic [per_pkg::NUM_AST-1:0]   ast_event,
    input  wire logic                          pwm0_match,
    input  wire logic [per_pkg::NUM_WAKE-1:0]  user_done,
    output logic      [PWM_CH-1:0]             pwm_duty_inc,
    output logic      [PWM_CH-1:0]             pwm_duty_dec,
    output logic                               touch_matrix_evt,
    output logic                               touch_iter_start,
    output logic      [per_pkg::NUM_TC_CH-1:0] tc0_capture,
    output logic      [per_pkg::NUM_TC_CH-1:0] tc1_capture,
    output logic                               cmp_meas_start,
    output logic                               adc_conv_start,
    output logic      [per_pkg::NUM_WAKE-1:0]  user_clk_req
);
    import per_pkg::*;

    localparam int PW = 2 * NUM_CMP + NUM_PA + NUM_PB + NUM_AST + 1;

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic [GEN_W-1:0]    gen_en_reg;
    logic [USR_W-1:0]    user_en_reg;
    logic [1:0]          cfg_reg;
    logic [2:0]          trg_reg;
    logic [COUNT_W-1:0]  count_reg;
    logic [NUM_WAKE-1:0] wake_reg;
    logic [NUM_WAKE-1:0] wake_hit;
    logic                wr_pend_reg;
    logic [7:0]          wr_addr_reg;
    logic                addr_ok;
    logic [PW-1:0]       all_p;
    logic [NUM_CMP-1:0]  above_p;
    logic [NUM_CMP-1:0]  below_p;
    logic [NUM_PA-1:0]   pa_p;
    logic [NUM_PB-1:0]   pb_p;
    logic [NUM_AST-1:0]  ast_p;
    logic                pwm0_p;
    logic                cmp_ok;
    logic                pin_ok;
    logic                ast_ok;
    logic                pwm_ok;
    logic                trig_ok;
    logic                cmp_mode_ok;
    logic                adc_mode_ok;
    logic                async_raw;
    logic [PWM_CH-1:0]   inc_next;
    logic [PWM_CH-1:0]   dec_next;
    logic [NUM_TC_CH-1:0] tc0_next;
    logic [NUM_TC_CH-1:0] tc1_next;
    logic                any_out;

    // Comparator channel to PWM channel table
    function automatic logic [4:0] pwm_of_cmp(input int k);
        logic [4:0] ch;
        ch = 5'h00;
        case (k)
            0: ch = 5'h00;
            1: ch = 5'h06;
            2: ch = 5'h08;
            3: ch = 5'h09;
            4: ch = 5'h0b;
            5: ch = 5'h0e;
            6: ch = 5'h13;
            7: ch = 5'h14;
            default: ch = 5'h00;
        endcase
        return ch;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    // Zero-wait OKAY slave
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Read data is loaded in the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                REG_GEN_EN:  hrdata <= {26'h0, gen_en_reg};
                REG_USER_EN: hrdata <= {28'h0, user_en_reg};
                REG_MODE:    hrdata <= {25'h0, trg_reg, 2'h0, cfg_reg};
                REG_COUNT:   hrdata <= {16'h0, count_reg};
                REG_WAKE:    hrdata <= {29'h0, wake_reg};
                default:     hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Writable enables and modes; read-only and unmapped writes drop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_en_reg  <= GEN_EN_RST;
            user_en_reg <= USER_EN_RST;
            cfg_reg     <= CFG_RST;
            trg_reg     <= TRG_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                REG_GEN_EN:  gen_en_reg  <= hwdata[GEN_W-1:0];
                REG_USER_EN: user_en_reg <= hwdata[USR_W-1:0];
                REG_MODE: begin
                    cfg_reg <= hwdata[CFG_LSB+:2];
                    trg_reg <= hwdata[TRG_LSB+:3];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Generator edges

    // All generator levels become single-cycle pulses
    per_edge_pulse #(
        .W (PW)
    ) u_pulse (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   ({pwm0_match, ast_event, pin_change_b, pin_change_a,
                   cmp_below, cmp_above}),
        .pulse   (all_p)
    );

    // Fixed slicing of the pulse vector
    assign above_p = all_p[0+:NUM_CMP];
    assign below_p = all_p[NUM_CMP+:NUM_CMP];
    assign pa_p    = all_p[2*NUM_CMP+:NUM_PA];
    assign pb_p    = all_p[2*NUM_CMP+NUM_PA+:NUM_PB];
    assign ast_p   = all_p[2*NUM_CMP+NUM_PA+NUM_PB+:NUM_AST];
    assign pwm0_p  = all_p[PW-1];

    // Generator side gating
    assign cmp_ok = gen_en_reg[GEN_CMP];
    assign pin_ok = gen_en_reg[GEN_PIN];
    assign ast_ok = |(ast_p & gen_en_reg[GEN_AST+:NUM_AST]);
    assign pwm_ok = pwm0_p && gen_en_reg[GEN_PWM0];

    // Timer and PWM0 events share the comparator and ADC inputs
    assign trig_ok     = ast_ok || pwm_ok;
    assign cmp_mode_ok = (cfg_reg == CMP_CFG_EVT) && user_en_reg[USR_CMP];
    assign adc_mode_ok = (trg_reg == ADC_TRG_EVT);

    ////////////////////////////////////////////////////////////////////
    // Routing

    // Comparator events to PWM duty steps
    always_comb begin
        inc_next = '0;
        dec_next = '0;
        for (int k = 0; k < NUM_CMP; k++) begin
            if (cmp_ok && user_en_reg[USR_PWM]) begin
                inc_next[pwm_of_cmp(k)] = above_p[k];
                dec_next[pwm_of_cmp(k)] = below_p[k];
            end
        end
    end

    // Pin-change groups to timer captures
    always_comb begin
        tc0_next = '0;
        tc1_next = '0;
        if (pin_ok && user_en_reg[USR_TC]) begin
            for (int i = 0; i < NUM_TC_CH; i++) begin
                tc0_next[i] = |pa_p[8*i+:8];
            end
            tc1_next[1] = |pb_p[0+:8];
            tc1_next[2] = |pb_p[8+:8];
        end
    end

    // Registered event outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_duty_inc     <= '0;
            pwm_duty_dec     <= '0;
            touch_matrix_evt <= 1'b0;
            touch_iter_start <= 1'b0;
            tc0_capture      <= '0;
            tc1_capture      <= '0;
            cmp_meas_start   <= 1'b0;
            adc_conv_start   <= 1'b0;
        end else begin
            pwm_duty_inc     <= inc_next;
            pwm_duty_dec     <= dec_next;
            touch_matrix_evt <= cmp_ok && (|below_p) && user_en_reg[USR_TOUCH];
            touch_iter_start <= ast_ok && user_en_reg[USR_TOUCH];
            tc0_capture      <= tc0_next;
            tc1_capture      <= tc1_next;
            cmp_meas_start   <= trig_ok && cmp_mode_ok;
            adc_conv_start   <= trig_ok && adc_mode_ok;
        end
    end

    // Counter of cycles with any delivered event, runs in any clocked sleep state
    assign any_out = (|pwm_duty_inc) || (|pwm_duty_dec) || touch_matrix_evt
                     || touch_iter_start || (|tc0_capture) || (|tc1_capture)
                     || cmp_meas_start || adc_conv_start;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
        end else if (any_out) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Async timer wake requests

    // Raw levels, so a request forms even before the edge is sampled
    assign async_raw = |(ast_event & gen_en_reg[GEN_AST+:NUM_AST]);
    assign wake_hit[WK_CMP]   = async_raw && cmp_mode_ok;
    assign wake_hit[WK_ADC]   = async_raw && adc_mode_ok;
    assign wake_hit[WK_TOUCH] = async_raw && user_en_reg[USR_TOUCH];

    // Held until the user reports done; a new hit wins over done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_reg <= '0;
        end else begin
            wake_reg <= wake_hit | (wake_reg & ~user_done);
        end
    end

    assign user_clk_req = wake_reg | wake_hit;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_ast_fire;
        ast_ok && user_en_reg[USR_TOUCH];
    endsequence

    sequence s_iter_once;
        touch_iter_start ##1 (!touch_iter_start || $past(ast_ok));
    endsequence

    a_inc_ch1_map: assert property (
        (above_p[1] && cmp_ok && user_en_reg[USR_PWM]) |=> pwm_duty_inc[6])
        else $error("comparator 1 above did not step PWM 6 up");

    a_dec_ch7_map: assert property (
        (below_p[7] && cmp_ok && user_en_reg[USR_PWM])
        |=> pwm_duty_dec[20] && !pwm_duty_inc[20])
        else $error("comparator 7 below did not step PWM 20 down");

    a_touch_matrix: assert property (
        touch_matrix_evt |-> $past(|below_p) && $past(cmp_ok))
        else $error("touch matrix event without comparator below");

    a_capture_grp: assert property (
        (pa_p[20] && pin_ok && user_en_reg[USR_TC])
        |=> tc0_capture[2] && !tc1_capture[0])
        else $error("port A high group did not capture");

    a_cmp_start_gate: assert property (
        cmp_meas_start |-> $past(cfg_reg) == CMP_CFG_EVT
                           && $past(user_en_reg[USR_CMP]))
        else $error("comparator start without event mode");

    a_adc_start_gate: assert property (
        adc_conv_start |-> $past(trg_reg) == ADC_TRG_EVT)
        else $error("ADC start without event trigger select");

    a_touch_iter: assert property (
        s_ast_fire |=> s_iter_once)
        else $error("timer event did not launch one iteration");

    a_pwm0_fanout: assert property (
        (pwm_ok && cmp_mode_ok && adc_mode_ok)
        |=> cmp_meas_start && adc_conv_start)
        else $error("PWM0 match did not reach both users");

    a_user_ignore: assert property (
        !user_en_reg[USR_PWM] |=> (pwm_duty_inc == '0) && (pwm_duty_dec == '0))
        else $error("disabled PWM user received an event");

    a_one_pulse: assert property (
        pwm_duty_inc[0] |=> !pwm_duty_inc[0])
        else $error("duty step pulse lasted two cycles");

    a_wake_hold: assert property (
        (wake_reg[WK_ADC] && !user_done[WK_ADC]) |=> wake_reg[WK_ADC]
        ##1 (wake_reg[WK_ADC] || $past(user_done[WK_ADC])))
        else $error("ADC wake request dropped before done");

endmodule

/* File: tb/per_user_model.sv */
// Model of the event users that finish work begun on a clock request.
// Assumes user_clk_req comes from the router in the hclk domain.
`timescale 1ns/1ns

module per_user_model
    import per_pkg::*;
#(
    parameter int DELAY = 4
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic [NUM_WAKE-1:0] user_clk_req,
    output logic      [NUM_WAKE-1:0] user_done
);
    int wait_cnt;

    // Report completion DELAY+1 cycles after a request shows up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt  <= 0;
            user_done <= '0;
        end else if (|user_clk_req && wait_cnt < DELAY) begin
            wait_cnt  <= wait_cnt + 1;
            user_done <= '0;
        end else begin
            wait_cnt  <= 0;
            user_done <= user_clk_req;
        end
    end
endmodule

/* File: tb/per_event_router_tb_top.sv */
// Self-checking bench for the event router: AHB-Lite register access
// and every fixed event path. Assumes one hclk domain at 100 MHz.
`timescale 1ns/1ns

module per_event_router_tb_top;
    import per_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  cmp_above;
    logic [7:0]  cmp_below;
    logic [23:0] pin_change_a;
    logic [15:0] pin_change_b;
    logic [2:0]  ast_event;
    logic        pwm0_match;
    logic [2:0]  user_done;
    logic [31:0] pwm_duty_inc;
    logic [31:0] pwm_duty_dec;
    logic        touch_matrix_evt;
    logic        touch_iter_start;
    logic [2:0]  tc0_capture;
    logic [2:0]  tc1_capture;
    logic        cmp_meas_start;
    logic        adc_conv_start;
    logic [2:0]  user_clk_req;
    logic [59:0] stim;
    logic [73:0] evt_out;
    logic [31:0] rdv;
    logic [15:0] exp_count;
    int          fail_count;
    int          samples_checked;
    int          pwm_map[8] = '{0, 6, 8, 9, 11, 14, 19, 20};

    // Single slave: its ready is the bus ready; generators from one vector
    assign hready = hreadyout;
    assign {cmp_above, cmp_below, pin_change_a, pin_change_b, ast_event, pwm0_match} = stim;
    assign evt_out = {pwm_duty_inc, pwm_duty_dec, touch_matrix_evt, touch_iter_start,
                      tc0_capture, tc1_capture, cmp_meas_start, adc_conv_start};

    per_event_router dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmp_above(cmp_above), .cmp_below(cmp_below), .pin_change_a(pin_change_a),
        .pin_change_b(pin_change_b), .ast_event(ast_event), .pwm0_match(pwm0_match),
        .user_done(user_done), .pwm_duty_inc(pwm_duty_inc), .pwm_duty_dec(pwm_duty_dec),
        .touch_matrix_evt(touch_matrix_evt), .touch_iter_start(touch_iter_start),
        .tc0_capture(tc0_capture), .tc1_capture(tc1_capture),
        .cmp_meas_start(cmp_meas_start), .adc_conv_start(adc_conv_start),
        .user_clk_req(user_clk_req));

    per_user_model #(.DELAY(4)) users (.hclk(hclk), .hresetn(hresetn),
        .user_clk_req(user_clk_req), .user_done(user_done));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [73:0] ev(logic [31:0] inc, logic [31:0] dec, logic tm,
                                       logic ti, logic [2:0] c0, logic [2:0] c1,
                                       logic cm, logic ad);
        return {inc, dec, tm, ti, c0, c1, cm, ad};
    endfunction

    function automatic logic [59:0] st(logic [7:0] ab, logic [7:0] be, logic [23:0] pa,
                                       logic [15:0] pb, logic [2:0] tmr, logic p0);
        return {ab, be, pa, pb, tmr, p0};
    endfunction

    task automatic conclude();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [73:0] exp, input logic [73:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    // Waits for the edge at which ready is high, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                conclude();
            end
            @(posedge hclk);
        end
    endtask

    // One single-word transfer; read data is taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rdv = hrdata;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, {42'h0, e}, {42'h0, rdv});
    endtask

    // Raise generator levels for one edge, then expect one pulse cycle
    task automatic fire(input string nm, input logic [59:0] s, input logic [73:0] e);
        @(posedge hclk);
        stim <= s;
        @(posedge hclk);
        stim <= 60'h0;
        #1;
        chk(nm, e, evt_out);
        @(posedge hclk);
        #1;
        chk({nm, " end"}, 74'h0, evt_out);
        if (e !== 74'h0) begin
            exp_count++;
        end
    endtask

    // Clock requests stand until the users report done
    task automatic wake_chk(input logic [2:0] e);
        int n;
        chk("wake request", {71'h0, e}, {71'h0, user_clk_req});
        n = 0;
        while (user_clk_req !== 3'h0) begin
            @(posedge hclk);
            #1;
            n++;
            if (n > 30) begin
                fail_count++;
                conclude();
            end
        end
        rd_chk("wake held", REG_WAKE, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_reset();
        logic [7:0] regs[6] = '{REG_GEN_EN, REG_USER_EN, REG_MODE, REG_COUNT, REG_WAKE, 8'h20};
        chk("idle outputs", 74'h0, evt_out);
        chk("hresp", 74'h0, {73'h0, hresp});
        chk("hreadyout", 74'h1, {73'h0, hreadyout});
        foreach (regs[i]) begin
            rd_chk("reset value", regs[i], 32'h0);
        end
        bus(1'b1, 8'h20, 32'hffffffff);
        rd_chk("unmapped", 8'h20, 32'h0);
    endtask

    task automatic s_cmp();
        bus(1'b1, REG_GEN_EN, 32'h1 << GEN_CMP);
        bus(1'b1, REG_USER_EN, (32'h1 << USR_PWM) | (32'h1 << USR_TOUCH));
        rd_chk("user enable", REG_USER_EN, 32'h9);
        for (int k = 0; k < 8; k++) begin
            fire("cmp above", st(8'h1 << k, 0, 0, 0, 0, 0),
                 ev(32'h1 << pwm_map[k], 0, 0, 0, 0, 0, 0, 0));
            fire("cmp below", st(0, 8'h1 << k, 0, 0, 0, 0),
                 ev(0, 32'h1 << pwm_map[k], 1, 0, 0, 0, 0, 0));
        end
        fire("cmp or", st(0, 8'h03, 0, 0, 0, 0), ev(0, 32'h41, 1, 0, 0, 0, 0, 0));
        bus(1'b1, REG_USER_EN, 32'h1 << USR_TOUCH);
        fire("pwm user off", st(8'h04, 0, 0, 0, 0, 0), 74'h0);
        fire("touch only", st(0, 8'h04, 0, 0, 0, 0), ev(0, 0, 1, 0, 0, 0, 0, 0));
        bus(1'b1, REG_GEN_EN, 32'h0);
        bus(1'b1, REG_USER_EN, 32'h9);
        fire("gen off", st(0, 8'h08, 0, 0, 0, 0), 74'h0);
    endtask

    task automatic s_pin();
        bus(1'b1, REG_GEN_EN, 32'h1 << GEN_PIN);
        bus(1'b1, REG_USER_EN, 32'h1 << USR_TC);
        for (int i = 0; i < 24; i++) begin
            fire("pin a", st(0, 0, 24'h1 << i, 0, 0, 0),
                 ev(0, 0, 0, 0, 3'h1 << (i / 8), 0, 0, 0));
        end
        for (int i = 0; i < 16; i++) begin
            fire("pin b", st(0, 0, 0, 16'h1 << i, 0, 0),
                 ev(0, 0, 0, 0, 0, 3'h2 << (i / 8), 0, 0));
        end
        bus(1'b1, REG_USER_EN, 32'h0);
        fire("capture off", st(0, 0, 24'hffffff, 16'hffff, 0, 0), 74'h0);
    endtask

    task automatic s_timer();
        bus(1'b1, REG_GEN_EN, 32'h1c);
        bus(1'b1, REG_USER_EN, 32'hc);
        bus(1'b1, REG_MODE, 32'h73);
        rd_chk("mode", REG_MODE, 32'h73);
        for (int j = 0; j < 3; j++) begin
            fire("timer", st(0, 0, 0, 0, 3'h1 << j, 0),
                 ev(0, 0, 0, 1, 0, 0, 1, 1));
            wake_chk(3'b111);
        end
        bus(1'b1, REG_MODE, 32'h72);
        fire("cfg 2", st(0, 0, 0, 0, 3'h1, 0), ev(0, 0, 0, 1, 0, 0, 0, 1));
        wake_chk(3'b110);
        bus(1'b1, REG_MODE, 32'h63);
        fire("trg 6", st(0, 0, 0, 0, 3'h2, 0), ev(0, 0, 0, 1, 0, 0, 1, 0));
        wake_chk(3'b101);
        bus(1'b1, REG_MODE, 32'h73);
        bus(1'b1, REG_USER_EN, 32'h8);
        fire("cmp input off", st(0, 0, 0, 0, 3'h4, 0), ev(0, 0, 0, 1, 0, 0, 0, 1));
        wake_chk(3'b110);
        bus(1'b1, REG_GEN_EN, 32'h1 << GEN_PWM0);
        bus(1'b1, REG_USER_EN, 32'h4);
        fire("pwm0 match", st(0, 0, 0, 0, 0, 1), ev(0, 0, 0, 0, 0, 0, 1, 1));
        wake_chk(3'b000);
        bus(1'b1, REG_GEN_EN, 32'h3c);
        bus(1'b1, REG_USER_EN, 32'hc);
        fire("timer or pwm0", st(0, 0, 0, 0, 3'h1, 1), ev(0, 0, 0, 1, 0, 0, 1, 1));
        wake_chk(3'b111);
    endtask

    task automatic s_count();
        rd_chk("pulse count", REG_COUNT, {16'h0, exp_count});
        bus(1'b1, REG_COUNT, 32'h0);
        rd_chk("count read only", REG_COUNT, {16'h0, exp_count});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Main sequence
    initial begin
        fail_count      = 0;
        samples_checked = 0;
        exp_count       = 16'h0;
        hresetn         = 1'b0;
        hsel            = 1'b0;
        haddr           = 32'h0;
        htrans          = 2'b00;
        hwrite          = 1'b0;
        hsize           = 3'h2;
        hwdata          = 32'h0;
        stim            = 60'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_cmp();
        s_pin();
        s_timer();
        s_count();
        conclude();
    end

    // Cuts a hang short
    initial begin
        #1000000;
        fail_count++;
        conclude();
    end
endmodule
